// *** rtl/scsp_clock_select.v ***
// System clock source select, PLL divisor control and instruction clock enable.
// Assumes one 10 MHz clock, synchronous active-high reset, AXI4-Lite master,
// configuration fields stable from reset onward.
// Limitation: no unlock sequence guards the control register.
// Writes act two edges after both halves are taken.
// Reads answer one edge after the address is taken.
`timescale 1ns/1ps
`include "scsp_consts.vh"

module scsp_clock_select
(
  input  wire        clock,          // System clock
  input  wire        srst,           // Synchronous reset, active high
  input  wire [2:0]  initSourceCfg,  // Initial source configuration
  input  wire [1:0]  primarySubCfg,  // Primary submode configuration
  input  wire        cfgErased,      // Configuration memory erased
  input  wire [1:0]  switchModeCfg,  // Switching/monitor configuration
  input  wire        clockFailEvt,   // Fail monitor detection pulse
  input  wire        pllLockIn,      // Lock indication from PLL
  input  wire [3:0]  s_axi_awaddr,   // Write address
  input  wire        s_axi_awvalid,  // Write address valid
  output reg         s_axi_awready,  // Write address ready
  input  wire [31:0] s_axi_wdata,    // Write data
  input  wire [3:0]  s_axi_wstrb,    // Write byte strobes
  input  wire        s_axi_wvalid,   // Write data valid
  output reg         s_axi_wready,   // Write data ready
  output reg  [1:0]  s_axi_bresp,    // Write response
  output reg         s_axi_bvalid,   // Write response valid
  input  wire        s_axi_bready,   // Write response ready
  input  wire [3:0]  s_axi_araddr,   // Read address
  input  wire        s_axi_arvalid,  // Read address valid
  output reg         s_axi_arready,  // Read address ready
  output reg  [31:0] s_axi_rdata,    // Read data
  output reg  [1:0]  s_axi_rresp,    // Read response
  output reg         s_axi_rvalid,   // Read data valid
  input  wire        s_axi_rready,   // Read data ready
  output reg  [2:0]  activeSource,   // Source now driving the system clock
  output reg  [1:0]  activeSubmode,  // Primary submode in use
  output reg         pllEnable,      // PLL in use
  output reg  [4:0]  preFactorM2,    // Prescale factor minus two
  output reg  [8:0]  fbFactorM2,     // Feedback factor minus two
  output reg  [3:0]  postFactor,     // Postscale factor 2, 4 or 8
  output reg  [8:0]  frcDivFactor,   // Fast RC divide factor
  output reg         instrClkEn      // Instruction clock enable, half rate
);

  // Register state
  reg  [2:0]  curSrc_r;       // Current source
  reg  [2:0]  reqSrc_r;       // Requested source
  reg         srcLock_r;      // Source lock
  reg         clkFail_r;      // Clock fail flag
  reg         swReq_r;        // Switch request
  reg  [15:0] clock_divisor_reg_r;       // Clock divisor register
  reg  [8:0]  fbDiv_r;        // Feedback divisor field
  reg  [1:0]  subMode_r;      // Primary submode captured on the first edge after reset
  reg         cfgLoad_r;      // Configuration sampled after reset
  reg  [3:0]  swCnt_r;        // Switch settle counter
  reg  [7:0]  lockCnt_r;      // PLL start-up timer
  reg         instrPh_r;      // Instruction clock phase

  // Bus holding state
  reg         awHeld_r;       // Write address captured
  reg         wHeld_r;        // Write data captured
  reg  [3:0]  awAddr_r;       // Captured write address
  reg  [31:0] wData_r;        // Captured write data
  reg  [3:0]  wStrb_r;        // Captured strobes

  // Combinational decodes
  wire [2:0]  cfgSrc;         // Effective power-on source
  wire        swAllowed;      // Clock switching usable
  wire        pllSel;         // Current source uses PLL
  wire        lockBit;        // PLL lock status
  wire        doWrite;        // Both write halves present
  wire [15:0] oscCtrlView;    // Control register as read
  wire [3:0]  wAddr;          // Effective write address
  wire [31:0] wData;          // Effective write data
  wire [3:0]  wStrb;          // Effective strobes
  wire        wrCtrl;         // Write to control register
  wire        lowLane;        // Low byte lane written
  wire        highLane;       // High byte lane written

  // Erased parts fall back to fast RC divide-by-N
  assign cfgSrc    = cfgErased ? `SCSP_CFG_ERASED_SRC : initSourceCfg; // [R1] [R2]
  // Switching needs the switching-enabled configuration
  assign swAllowed = (switchModeCfg == `SCSP_CKSM_SW_ONLY) ||
                     (switchModeCfg == 2'h0);
  // Only fast RC and primary can feed the PLL
  assign pllSel    = (curSrc_r == `SCSP_SRC_FRC_PLL) ||
                     (curSrc_r == `SCSP_SRC_PRI_PLL); // [R5]
  // Lock shows once locked and timer done; zero with PLL off
  assign lockBit   = pllSel && pllLockIn && (lockCnt_r == 8'h00); // [R17]

  // Control image; unused bits read zero
  assign oscCtrlView = {1'b0, curSrc_r, 1'b0, reqSrc_r, srcLock_r, 1'b0,
                        lockBit, 1'b0, clkFail_r, 2'b00, swReq_r}; // [R14]

  // Write fields come from the held copies
  assign wAddr    = awHeld_r ? awAddr_r : s_axi_awaddr;
  assign wData    = wHeld_r ? wData_r : s_axi_wdata;
  assign wStrb    = wHeld_r ? wStrb_r : s_axi_wstrb;
  // Act only once both halves are held: live valids would block ready
  assign doWrite  = awHeld_r && wHeld_r && !s_axi_bvalid;
  // Control write and byte lanes
  assign wrCtrl   = doWrite && (wAddr == `SCSP_OSC_CTRL_ADDR);
  assign lowLane  = wStrb[0];
  assign highLane = wStrb[1];

  // Write channel: capture each half separately, respond once both are held
  always @(posedge clock)
  begin
    if (srst)
    begin
      // Nothing held, no answer pending
      awHeld_r      <= 1'b0;
      wHeld_r       <= 1'b0;
      awAddr_r      <= 4'h0;
      wData_r       <= 32'h00000000;
      wStrb_r       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end
    else
    begin
      // Ready is offered one cycle ahead for a half not yet held
      // and stays low until the last response is taken
      s_axi_awready <= !awHeld_r && !(s_axi_awvalid && s_axi_awready) &&
                       !s_axi_bvalid && !doWrite;
      s_axi_wready  <= !wHeld_r && !(s_axi_wvalid && s_axi_wready) &&
                       !s_axi_bvalid && !doWrite;
      // Address half taken
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end
      // Data half taken with its strobes
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      // Both held: answer, free the slots
      if (awHeld_r && wHeld_r && !s_axi_bvalid)
      begin
        // Addresses above the status register answer with a slave error
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awAddr_r > `SCSP_STATUS_ADDR) ? 2'b10 : 2'b00;
        awHeld_r     <= 1'b0;
        wHeld_r      <= 1'b0;
      end
      // Answer stands until taken
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register updates and clock switch sequencing
  always @(posedge clock)
  begin
    if (srst)
    begin
      // Park on fast RC until config is read
      curSrc_r  <= `SCSP_SRC_FRC;
      reqSrc_r  <= `SCSP_SRC_FRC;
      subMode_r <= `SCSP_PRI_EXT;
      cfgLoad_r <= 1'b1;
      srcLock_r <= 1'b0;
      clkFail_r <= 1'b0;
      swReq_r   <= 1'b0;
      clock_divisor_reg_r  <= `SCSP_CLOCK_DIVISOR_REG_RESET; // [R20]
      fbDiv_r   <= `SCSP_FBD_RESET;    // [R19]
      swCnt_r   <= 4'h0;
      lockCnt_r <= 8'h00;
    end
    else if (cfgLoad_r)
    begin
      // Configuration is caught on the first edge after release
      cfgLoad_r <= 1'b0;
      curSrc_r  <= cfgSrc;        // [R1]
      reqSrc_r  <= cfgSrc;        // [R15]
      subMode_r <= primarySubCfg; // [R13]
      // Timer armed in case the source uses the PLL
      lockCnt_r <= `SCSP_LOCK_CYCLES;
    end
    else
    begin
      // Start-up timer runs while the PLL is selected
      // and stops at zero, where lock may show
      if (pllSel && lockCnt_r != 8'h00)
        lockCnt_r <= lockCnt_r - 8'h01;
      // Register writes
      if (doWrite && wAddr == `SCSP_CLK_DIV_ADDR)
      begin
        if (lowLane)
          // Bit 5 is unimplemented, kept zero
          clock_divisor_reg_r[7:0] <= {wData[7:6], 1'b0, wData[4:0]}; // [R6] [R8]
        if (highLane)
          clock_divisor_reg_r[15:8] <= wData[15:8]; // [R4]
      end
      // Upper lane carries feedback bit 8
      if (doWrite && wAddr == `SCSP_FB_DIV_ADDR)
      begin
        if (lowLane)
          fbDiv_r[7:0] <= wData[7:0]; // [R7]
        if (highLane)
          fbDiv_r[8] <= wData[8];
      end
      // New source only when enabled, unlocked
      if (wrCtrl && highLane && swAllowed && !srcLock_r)
        reqSrc_r <= wData[`SCSP_REQ_SRC_MSB:`SCSP_REQ_SRC_LSB]; // [R15] [R16]
      // Lock and switch bits ignored when off
      if (wrCtrl && lowLane && swAllowed)
      begin
        // Lock bit is sticky once set until reset
        if (wData[`SCSP_SRC_LOCK_BIT])
          srcLock_r <= 1'b1; // [R16]
        if (wData[`SCSP_SWITCH_BIT] && !srcLock_r && !swReq_r)
        begin
          swReq_r <= 1'b1; // [R21]
          swCnt_r <= `SCSP_SWITCH_CYCLES;
        end
      end
      // Fail flag: monitor set wins over a software clear
      if (clockFailEvt)
        clkFail_r <= 1'b1; // [R18]
      else if (wrCtrl && lowLane && !wData[`SCSP_CLK_FAIL_BIT])
        clkFail_r <= 1'b0; // [R18]
      // Switch sequence: settle count, then adopt the new source
      // Ten counts stand in for the new clock's settling
      if (swReq_r)
      begin
        // Same source: drop the request
        if (reqSrc_r == curSrc_r)
          swReq_r <= 1'b0; // [R21]
        else if (swCnt_r != 4'h0)
          swCnt_r <= swCnt_r - 4'h1;
        else
        begin
          // Adopt it and restart the lock timer
          curSrc_r  <= reqSrc_r; // [R12]
          swReq_r   <= 1'b0;     // [R21]
          lockCnt_r <= `SCSP_LOCK_CYCLES;
        end
      end
    end
  end

  // Read channel: one cycle to accept, answer on the next
  always @(posedge clock)
  begin
    if (srst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'b00;
    end
    else
    begin
      // Ready pulses once, low while data waits
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'b00;
        // Address still stands here
        case (s_axi_araddr)
          `SCSP_OSC_CTRL_ADDR: s_axi_rdata <= {16'h0000, oscCtrlView};
          `SCSP_CLK_DIV_ADDR:  s_axi_rdata <= {16'h0000, clock_divisor_reg_r};
          `SCSP_FB_DIV_ADDR:   s_axi_rdata <= {23'h000000, fbDiv_r};
          `SCSP_STATUS_ADDR:   s_axi_rdata <= {27'h0000000, subMode_r, curSrc_r};
          // Unmapped or misaligned: error
          default:
          begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end
      // Data stands until taken
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Decoded clock settings for the analog side, and the half-rate enable
  always @(posedge clock)
  begin
    if (srst)
    begin
      // Defaults: post 2, fast RC 1, feedback 50
      activeSource  <= `SCSP_SRC_FRC;
      activeSubmode <= `SCSP_PRI_EXT;
      pllEnable     <= 1'b0;
      preFactorM2   <= 5'h00;
      fbFactorM2    <= `SCSP_FBD_RESET;
      postFactor    <= 4'h2;
      frcDivFactor  <= 9'h001;
      instrClkEn    <= 1'b0;
      instrPh_r     <= 1'b0;
    end
    else
    begin
      // Settings lag the registers by one edge
      activeSource  <= curSrc_r;
      activeSubmode <= subMode_r;       // [R13]
      pllEnable     <= pllSel;          // [R5]
      // Prescale and feedback leave as factor minus two
      preFactorM2   <= clock_divisor_reg_r[`SCSP_PRE_MSB:`SCSP_PRE_LSB]; // [R6]
      fbFactorM2    <= fbDiv_r;         // [R7] [R19]
      // Code 10 is reserved; it is treated as the largest divide
      case (clock_divisor_reg_r[`SCSP_POST_MSB:`SCSP_POST_LSB])
        2'h0:    postFactor <= 4'h2; // [R8]
        2'h1:    postFactor <= 4'h4;
        default: postFactor <= 4'h8;
      endcase
      // Divide-by-16 mode is fixed; divide-by-N uses the postscaler
      if (curSrc_r == `SCSP_SRC_FRC_DIV16)
        frcDivFactor <= 9'h010;
      else if (curSrc_r == `SCSP_SRC_FRC_DIVN)
        case (clock_divisor_reg_r[`SCSP_FRCDIV_MSB:`SCSP_FRCDIV_LSB])
          3'h7:    frcDivFactor <= 9'h100; // [R20]
          default: frcDivFactor <= 9'h001 << clock_divisor_reg_r[`SCSP_FRCDIV_MSB:`SCSP_FRCDIV_LSB]; // [R4]
        endcase
      else
        frcDivFactor <= 9'h001;
      // One enable every second system clock
      // Phase starts low: first pulse two edges after reset
      instrPh_r  <= ~instrPh_r;
      instrClkEn <= instrPh_r; // [R3]
    end
  end

endmodule // scsp_clock_select

// *** rtl/scsp_consts.vh ***
// Constants for the system clock select and PLL control block.
// Assumes a 10 MHz system clock and an AXI4-Lite register bus with 32-bit data.
//
// Summary of operation
// [R1] Power-on source from configuration source and submode
// [R2] Erased configuration selects fast RC divide-by-N
// [R3] Instruction clock is selected clock divided by two
// [R4] Fast RC postscaler field at divisor bits 10:8
// [R5] PLL fed only by primary or fast RC
// [R6] Prescale factor is field plus two, 2..33
// [R7] Feedback factor is field value plus two
// [R8] Postscale factor 2, 4 or 8 from bits 7:6
// [R9] Software keeps VCO input within 0.8-8 MHz
// [R10] Software keeps VCO output within 100-200 MHz
// [R11] Software keeps PLL output within 12.5-80 MHz
// [R12] Three-bit source code maps eight source selections
// [R13] Primary submode: 10 fast crystal, 01 crystal, 00 external
// [R14] Current source field at control bits 14:12
// [R15] Requested source bits 10:8, reset from configuration
// [R16] Source lock blocks switching when switching-only configuration
// [R17] PLL lock status bit 5 shows lock
// [R18] Clock fail flag set by monitor, cleared by zero
// [R19] Feedback field 0..511 gives 2..513, default 50
// [R20] Fast RC divide codes 1,2,4,...,64,256, default 1
// [R21] Switch request bit 0 cleared when switch completes
`ifndef SCSP_CONSTS_VH
`define SCSP_CONSTS_VH

// Register byte offsets
`define SCSP_OSC_CTRL_ADDR   4'h0
`define SCSP_CLK_DIV_ADDR    4'h4
`define SCSP_FB_DIV_ADDR     4'h8
`define SCSP_STATUS_ADDR     4'hc

// Oscillator control field positions
`define SCSP_CUR_SRC_MSB     14
`define SCSP_CUR_SRC_LSB     12
`define SCSP_REQ_SRC_MSB     10
`define SCSP_REQ_SRC_LSB     8
`define SCSP_SRC_LOCK_BIT    7
`define SCSP_PLL_LOCK_BIT    5
`define SCSP_CLK_FAIL_BIT    3
`define SCSP_SWITCH_BIT      0

// Clock divisor field positions
`define SCSP_FRCDIV_MSB      10
`define SCSP_FRCDIV_LSB      8
`define SCSP_POST_MSB        7
`define SCSP_POST_LSB        6
`define SCSP_PRE_MSB         4
`define SCSP_PRE_LSB         0

// Reset values
`define SCSP_CLOCK_DIVISOR_REG_RESET    16'h0040
`define SCSP_FBD_RESET       9'h030
`define SCSP_CFG_ERASED_SRC  3'h7

// Source selection codes
`define SCSP_SRC_FRC         3'h0
`define SCSP_SRC_FRC_PLL     3'h1
`define SCSP_SRC_PRI         3'h2
`define SCSP_SRC_PRI_PLL     3'h3
`define SCSP_SRC_SEC         3'h4
`define SCSP_SRC_SLOW_INTERNAL_OSC        3'h5
`define SCSP_SRC_FRC_DIV16   3'h6
`define SCSP_SRC_FRC_DIVN    3'h7

// Primary submode codes
`define SCSP_PRI_EXT         2'h0
`define SCSP_PRI_XTAL        2'h1
`define SCSP_PRI_HS          2'h2

// Switching configuration: switching on, monitor off
`define SCSP_CKSM_SW_ONLY    2'h1

// Timing: new clock settles over this many cycles before the switch
`define SCSP_SWITCH_CYCLES   4'ha
// PLL start-up wait: 20 us at 10 MHz, sized for the 8-bit timer
`define SCSP_LOCK_CYCLES     8'hc8

`endif

// *** dv/scsp_clock_select_asserts.sv ***
// Port-level assertions for the clock select and PLL control block.
// Assumes a bind onto scsp_clock_select, one clock and a synchronous reset.
`timescale 1ns/1ps
module scsp_clock_select_asserts
(
  input wire        clock,         // System clock
  input wire        srst,          // Sync reset, active high
  input wire        s_axi_wvalid,  // Write data valid
  input wire        s_axi_wready,  // Write data ready
  input wire        s_axi_bvalid,  // Write response valid
  input wire [3:0]  s_axi_araddr,  // Read address
  input wire        s_axi_arvalid, // Read address valid
  input wire        s_axi_arready, // Read address ready
  input wire [31:0] s_axi_rdata,   // Read data
  input wire [1:0]  s_axi_rresp,   // Read response
  input wire        s_axi_rvalid,  // Read data valid
  input wire        s_axi_rready,  // Read data ready
  input wire [2:0]  activeSource,  // Source in use
  input wire        pllEnable,     // PLL in use
  input wire [8:0]  fbFactorM2,    // Feedback factor minus two
  input wire [3:0]  postFactor,    // Postscale factor
  input wire [8:0]  frcDivFactor,  // Fast RC divide factor
  input wire        instrClkEn     // Instruction clock enable
);
  // One domain, so clock and reset guard are given once
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  // Half rate: each pulse is followed by one idle cycle, then the next pulse
  a_instr_half: assert property (instrClkEn |=> !instrClkEn ##1 instrClkEn)
    else $error("Instruction enable is not half rate");
  // Feedback, fast RC and postscale outputs leave reset at their defaults
  a_reset_dflt: assert property ($fell(srst) |->
    fbFactorM2 == 9'h030 && frcDivFactor == 9'h001 && postFactor == 4'h2)
    else $error("Divider outputs wrong after reset");
  // Guarded by a steady source so a one-cycle update skew is tolerated
  a_pll_source: assert property ($stable(activeSource) |->
    pllEnable == (activeSource == 3'h1 || activeSource == 3'h3))
    else $error("PLL enable does not match source");
  a_post_legal: assert property (postFactor inside {4'h2, 4'h4, 4'h8})
    else $error("Postscale factor not 2, 4 or 8");
  a_frc_fixed: assert property ($stable(activeSource) && activeSource != 3'h7 |->
    frcDivFactor == ((activeSource == 3'h6) ? 9'h010 : 9'h001))
    else $error("Fast RC divide wrong for source");
  // Divide by 128 does not exist in the code table
  a_frc_power: assert property ($onehot(frcDivFactor) && !frcDivFactor[7])
    else $error("Fast RC divide not a legal power of two");
  a_write_resp: assert property (s_axi_wvalid && s_axi_wready |-> ##[1:4] s_axi_bvalid)
    else $error("Write response late");
  a_read_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read data late");
  a_read_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("Read data repeated");
  a_read_refuse: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 4'hc |=>
    s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
    else $error("Unmapped read not refused");
endmodule // scsp_clock_select_asserts

bind scsp_clock_select scsp_clock_select_asserts u_chk
(
  .clock(clock), .srst(srst), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .activeSource(activeSource),
  .pllEnable(pllEnable), .fbFactorM2(fbFactorM2), .postFactor(postFactor),
  .frcDivFactor(frcDivFactor), .instrClkEn(instrClkEn)
);

// *** dv/tb.sv ***
// Self-checking bench for the clock select block over its register bus.
// Assumes the block's constants header is on the include path.
`timescale 1ns/1ps
`include "scsp_consts.vh"
module tb;
  logic        clock, srst, cfgErased, clockFailEvt, pllLockIn;     // Clock, reset, inputs
  logic [2:0]  initSourceCfg, activeSource;                        // Source codes
  logic [1:0]  primarySubCfg, switchModeCfg, activeSubmode;        // Configuration fields
  logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr, postFactor; // Addresses, strobes
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;                       // Bus data
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp, p;                   // Responses, post code
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;  // Write handshake
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;  // Answer, read
  logic        s_axi_rvalid, s_axi_rready, pllEnable, instrClkEn;         // Read data, status
  logic [4:0]  preFactorM2, n;                                     // Prescale
  logic [8:0]  fbFactorM2, frcDivFactor, f;                        // Feedback, fast RC
  logic [2:0]  e;                                                  // Expected source
  int          error_cnt = 0;                                      // Mismatches
  int          check_count = 0;                                    // Comparisons
  int          cycles = 0;                                         // Cycles run

  scsp_clock_select uut
  (
    .clock, .srst, .initSourceCfg, .primarySubCfg, .cfgErased, .switchModeCfg,
    .clockFailEvt, .pllLockIn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .activeSource, .activeSubmode, .pllEnable,
    .preFactorM2, .fbFactorM2, .postFactor, .frcDivFactor, .instrClkEn
  );

  // 10 MHz clock
  always #50 clock = ~clock;

  // Whole run needs under a thousand cycles, so this only trips on a hang
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      error_cnt++;
      print_verdict();
    end
  end

  task print_verdict();
  begin
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
  begin
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  end
  endtask

  // Fast RC divide for a code: powers of two, top code jumps to 256
  function automatic logic [8:0] frcExp(input logic [2:0] c);
    return (c == 3'h7) ? 9'h100 : 9'(1 << c);
  endfunction

  // Postscale for a code; reserved code reads as 8
  function automatic logic [3:0] postExp(input logic [1:0] c);
    return (c == 2'h0) ? 4'h2 : (c == 2'h1) ? 4'h4 : 4'h8;
  endfunction

  // Ready is registered, so its level at the falling edge is what the rising edge takes
  task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    logic ta, tw, got;
  begin
    @(posedge clock);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(negedge clock);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      @(posedge clock);
      if (ta)
        s_axi_awvalid <= 1'b0;
      if (tw)
        s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid || s_axi_wvalid ? !(ta && tw) && (s_axi_awvalid && !ta
               || s_axi_wvalid && !tw) : 1'b0);
    do
    begin
      @(negedge clock);
      got = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge clock);
    end while (!got);
    s_axi_bready <= 1'b0;
  end
  endtask

  task automatic axr(input logic [3:0] a);
    logic got;
  begin
    @(posedge clock);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(negedge clock);
      got = s_axi_arready;
      @(posedge clock);
    end while (!got);
    s_axi_arvalid <= 1'b0;
    do
    begin
      @(negedge clock);
      got = s_axi_rvalid;
      rd  = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge clock);
    end while (!got);
    s_axi_rready <= 1'b0;
  end
  endtask

  // Reset 20 cycles with a new power-on configuration
  task automatic do_reset(input logic [2:0] src, input logic erased);
  begin
    @(posedge clock);
    srst          <= 1'b1;
    initSourceCfg <= src;
    cfgErased     <= erased;
    primarySubCfg <= 2'($urandom % 3);
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    repeat (4) @(posedge clock);
  end
  endtask

  // Let registered outputs land before looking at them
  task automatic settle();
  begin
    repeat (2) @(posedge clock);
    @(negedge clock);
  end
  endtask

  initial
  begin
    clock = 1'b0;
    {srst, cfgErased, clockFailEvt, pllLockIn} = 4'h8;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {initSourceCfg, primarySubCfg, s_axi_awaddr, s_axi_wstrb, s_axi_araddr, s_axi_wdata} = '0;
    switchModeCfg = 2'h1;
    void'($urandom(32'h50398fa7));
    // Every source code at power-on, last pass with erased configuration
    for (int i = 0; i < 9; i++)
    begin
      do_reset(3'(i), i == 8);
      e = (i == 8) ? 3'h7 : 3'(i);
      axr(`SCSP_OSC_CTRL_ADDR);
      check(rd & 32'h7700, 32'({e, 1'b0, e, 8'h00}));
      axr(`SCSP_STATUS_ADDR);
      check(rd & 32'h1f, 32'({primarySubCfg, e}));
      axr(`SCSP_CLK_DIV_ADDR);
      check(rd & 32'hffff, 32'h0040);
      axr(`SCSP_FB_DIV_ADDR);
      check(rd & 32'h1ff, 32'h030);
      @(negedge clock);
      f[0] = instrClkEn;
      @(negedge clock);
      check(32'(f[0] ^ instrClkEn), 32'h1);
      check(32'(activeSubmode), 32'(primarySubCfg));
      check(32'(activeSource), 32'(e));
      check(32'(pllEnable), 32'(e == 3'h1 || e == 3'h3));
      check(32'(frcDivFactor), (e == 3'h6) ? 32'h10 : 32'h1);
    end
    $display("test 1 done");
    // Divisor fields with every fast RC code, source left on divide-by-N
    for (int i = 0; i < 8; i++)
    begin
      p = 2'($urandom);
      n = (i == 7) ? 5'h1f : 5'($urandom);
      axw(`SCSP_CLK_DIV_ADDR, 32'({3'(i), p, 1'b0, n}), 4'h3);
      axr(`SCSP_CLK_DIV_ADDR);
      check(rd & 32'h7df, 32'({3'(i), p, 1'b0, n}));
      settle();
      check(32'(preFactorM2), 32'(n));
      check(32'(postFactor), 32'(postExp(p)));
      check(32'(frcDivFactor), 32'(frcExp(3'(i))));
    end
    $display("test 2 done");
    // Feedback field: worked example, top value, random
    for (int i = 0; i < 4; i++)
    begin
      f = (i == 0) ? 9'h01e : (i == 1) ? 9'h1ff : 9'($urandom);
      axw(`SCSP_FB_DIV_ADDR, 32'(f), 4'h3);
      axr(`SCSP_FB_DIV_ADDR);
      check(rd & 32'h1ff, 32'(f));
      settle();
      check(32'(fbFactorM2), 32'(f));
    end
    $display("test 3 done");
    // Switch to fast RC with PLL, then wait out the lock start-up
    @(posedge clock);
    pllLockIn <= 1'b1;
    // Divisors keep a fast RC input inside the PLL's ranges
    axw(`SCSP_CLK_DIV_ADDR, 32'h0, 4'h3);
    axw(`SCSP_FB_DIV_ADDR, 32'h1e, 4'h3);
    axw(`SCSP_OSC_CTRL_ADDR, 32'h0100, 4'h3);
    axw(`SCSP_OSC_CTRL_ADDR, 32'h0101, 4'h3);
    for (int k = 0; k < 20 && (k == 0 || rd[0]); k++)
      axr(`SCSP_OSC_CTRL_ADDR);
    check(rd & 32'h7021, 32'h1000);
    for (int k = 0; k < 150 && !rd[5]; k++)
      axr(`SCSP_OSC_CTRL_ADDR);
    check(32'(rd[5]), 32'h1);
    pllLockIn <= 1'b0;
    settle();
    axr(`SCSP_OSC_CTRL_ADDR);
    check(32'(rd[5]), 32'h0);
    $display("test 4 done");
    // Clock fail flag set by the monitor, cleared by writing zero
    @(posedge clock);
    clockFailEvt <= 1'b1;
    @(posedge clock);
    clockFailEvt <= 1'b0;
    settle();
    axr(`SCSP_OSC_CTRL_ADDR);
    check(32'(rd[3]), 32'h1);
    axw(`SCSP_OSC_CTRL_ADDR, 32'h0, 4'h1);
    axr(`SCSP_OSC_CTRL_ADDR);
    check(32'(rd[3]), 32'h0);
    $display("test 5 done");
    // Source lock set: a new request is ignored
    axw(`SCSP_OSC_CTRL_ADDR, 32'h0080, 4'h1);
    axw(`SCSP_OSC_CTRL_ADDR, 32'h0281, 4'h3);
    settle();
    axr(`SCSP_OSC_CTRL_ADDR);
    check(rd & 32'h7780, 32'h1180);
    check(32'(activeSource), 32'h1);
    // Unmapped places are refused
    axr(4'hd);
    check(32'(rsp), 32'h2);
    axw(4'he, 32'hffff, 4'hf);
    check(32'(rsp), 32'h2);
    $display("test 6 done");
    print_verdict();
  end
endmodule // tb
